/* bench/hbss_brake_model.sv */
// mechanical brake actuator fed from one programmable output terminal
// assumes the terminal level is high while the brake must be released
`timescale 1ns/1ps
module hbss_brake_model #(
  parameter int LAG = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic releaseCmd,
  output logic brakeOpen
);
  int cnt;
  // the shoe lifts only after the coil has been fed LAG cycles; springs close at once
  always_ff @(posedge clk) begin
    if (!rst_n || !releaseCmd) begin
      cnt <= 0;
      brakeOpen <= 1'b0;
    end else begin
      cnt <= (cnt < LAG) ? cnt + 1 : cnt;
      brakeOpen <= (cnt >= LAG - 1);
    end
  end
endmodule

/* bench/hbss_props.sv */
// checker for the hoist brake signal sequencer, watching its ports only
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/1ps
module hbss_props #(
  parameter int NUM_TERMINALS = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [15:0] outCurrent,
  input wire logic [15:0] outFreq,
  input wire logic [15:0] torqueCmd,
  input wire logic [15:0] refSpeed,
  input wire logic [15:0] detSpeed,
  input wire logic runCmd,
  input wire logic alarmTrip,
  input wire logic coast_stop_cmd,
  input wire logic [1:0] motorSelect,
  input wire logic brake_release_out,
  input wire logic [NUM_TERMINALS-1:0] terminalOut
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic forceOn;
  logic lockQ;
  logic prevQ;
  logic f1Q;
  logic f2Q;
  // any forcing cause bypasses every dwell timer
  assign forceOn = alarmTrip || coast_stop_cmd || (motorSelect != 2'h0);
  // a drop with no forcing around it locks out release until run goes low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lockQ <= 1'b0;
      prevQ <= 1'b0;
      f1Q <= 1'b0;
      f2Q <= 1'b0;
    end else begin
      prevQ <= brake_release_out;
      f1Q <= forceOn;
      f2Q <= f1Q;
      lockQ <= runCmd && (lockQ || (prevQ && !brake_release_out && !f1Q && !f2Q));
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence stopSeq;
    alarmTrip || coast_stop_cmd;
  endsequence
  sequence readFar;
    hsel && hready && htrans[1] && !hwrite && (haddr[31:8] != 24'h0);
  endsequence
  property lockedOut;
    lockQ && runCmd && !forceOn |=> !brake_release_out;
  endproperty
  a_stop_forces_on: assert property (stopSeq |=> brake_release_out)
    else $error("brake output not on after alarm or coast stop");
  a_other_motor_on: assert property (motorSelect != 2'h0 |=> brake_release_out)
    else $error("brake output not held on for another motor");
  a_rise_has_cause: assert property ($rose(brake_release_out) && $past(rst_n) |->
    $past(runCmd || forceOn))
    else $error("brake output rose without run or forcing");
  a_fall_not_forced: assert property ($fell(brake_release_out) && $past(rst_n) |->
    !$past(forceOn))
    else $error("brake output fell while forced on");
  a_lockout_holds: assert property (lockedOut)
    else $error("brake released again without run cycling");
  a_terminal_follows: assert property (|terminalOut |-> brake_release_out)
    else $error("terminal on while brake output off");
  a_bus_zero_wait: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  a_unmapped_zero: assert property (readFar |=> hrdata == 32'h0)
    else $error("read outside the map not zero");
endmodule
bind hbss_sequencer hbss_props #(.NUM_TERMINALS(NUM_TERMINALS)) i_props (
  .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .outCurrent(outCurrent), .outFreq(outFreq), .torqueCmd(torqueCmd),
  .refSpeed(refSpeed), .detSpeed(detSpeed), .runCmd(runCmd), .alarmTrip(alarmTrip),
  .coast_stop_cmd(coast_stop_cmd), .motorSelect(motorSelect),
  .brake_release_out(brake_release_out), .terminalOut(terminalOut));

/* bench/tb_top.sv */
// testbench for the hoist brake signal sequencer
// assumes package, sequencer, checker and brake model are compiled first
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  logic clk, rst_n, hsel, hwrite, runCmd, alarmTrip, coastStop, hreadyout, hresp;
  logic brake, brakeOpen;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, motorSelect;
  logic [2:0] hsize;
  logic [15:0] outCurrent, outFreq, torqueCmd, refSpeed, detSpeed;
  logic [5:0] terminalOut;
  int miscompares = 0;
  int checks = 0;
  int regQ[$];
  int ratedQ[$];
  int thr;
  // short tick keeps the 0.1 s dwell steps at four cycles
  hbss_sequencer #(.TICK_CYCLES(4), .NUM_TERMINALS(6)) i_dut (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .outCurrent(outCurrent), .outFreq(outFreq), .torqueCmd(torqueCmd),
    .refSpeed(refSpeed), .detSpeed(detSpeed), .runCmd(runCmd), .alarmTrip(alarmTrip),
    .coast_stop_cmd(coastStop), .motorSelect(motorSelect), .brake_release_out(brake),
    .terminalOut(terminalOut));
  hbss_brake_model #(.LAG(3)) i_brake (
    .clk(clk), .rst_n(rst_n), .releaseCmd(terminalOut[2]), .brakeOpen(brakeOpen));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  // single word transfer; a stuck ready ends the run
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    bit stuck;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    stuck = hreadyout !== 1'b1;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    // a wait that runs out is a failure of its own
    if (stuck || hreadyout !== 1'b1) begin
      miscompares++;
      print_verdict();
    end
  endtask
  // dwell window counted in cycles from the input change; returns on the
  // following rising edge so that callers drive inputs at an edge
  task automatic waitOut(input logic exp, input int lo, input int hi);
    int n;
    n = 0;
    while (brake !== exp && n <= hi) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("brake_release_out", {31'h0, brake}, {31'h0, exp});
    chk("dwell window", {31'h0, n >= lo && n <= hi}, 32'h1);
    if (n > hi) begin
      print_verdict();
    end else begin
      @(posedge clk);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {rst_n, hsel, hwrite, runCmd, alarmTrip, coastStop} = '0;
    {haddr, hwdata, htrans, motorSelect, hsize} = '0;
    {outCurrent, outFreq, torqueCmd, refSpeed, detSpeed} = '0;
    void'($urandom(21281));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // address, write data, expected read; clamps first, final values last
    // 0x48 is past the last terminal and 0x104 lies outside the map: both read zero
    regQ = '{4, 32'h1ff, 300, 4, 150, 150, 12, 60, 50, 12, 2, 2, 8, 255, 250, 8, 10, 10,
      56, 57, 57, 40, 50, 50, 44, 200, 200, 28, 20, 20, 72, 5, 0, 32'h104, 7, 0};
    for (int i = 0; i < regQ.size(); i += 3) begin
      ahb(1'b1, regQ[i], regQ[i+1]);
      ahb(1'b0, regQ[i], 32'h0);
      chk("register", rd, regQ[i+2]);
    end
    $display("test registers done");
    runCmd <= 1'b1;
    outFreq <= 16'(11 + $urandom_range(239));
    waitOut(1'b1, 4, 11);
    repeat (4) @(posedge clk);
    chk("terminals", terminalOut, 6'h04);
    chk("actuator", brakeOpen, 1'b1);
    runCmd <= 1'b0;
    outFreq <= 16'h0;
    waitOut(1'b0, 0, 7);
    runCmd <= 1'b1;
    repeat (6) begin
      outFreq <= 16'h64;
      repeat (3) @(posedge clk);
      outFreq <= 16'h0;
      @(posedge clk);
    end
    chk("broken dwell", brake, 1'b0);
    $display("test frequency dwell done");
    ratedQ = '{100, 50, 200};
    for (int d = 0; d < 3; d++) begin
      thr = 150 * ratedQ[d] / 100;
      ahb(1'b1, 32'h0, 32'(d << 2));
      runCmd <= 1'b1;
      outCurrent <= 16'(thr);
      repeat (15) @(posedge clk);
      chk("current at level", brake, 1'b0);
      outCurrent <= 16'(thr + 1);
      waitOut(1'b1, 4, 11);
      runCmd <= 1'b0;
      outCurrent <= 16'h0;
      waitOut(1'b0, 0, 7);
    end
    $display("test current duty done");
    ahb(1'b1, 32'h0, 32'h1);
    runCmd <= 1'b1;
    {outFreq, refSpeed, detSpeed} <= {16'hfa, 16'h64, 16'h64};
    repeat (15) @(posedge clk);
    chk("frequency ignored", brake, 1'b0);
    torqueCmd <= 16'(101 + $urandom_range(199));
    waitOut(1'b1, 4, 11);
    detSpeed <= 16'h5;
    waitOut(1'b0, 0, 7);
    repeat (20) @(posedge clk);
    chk("lockout", brake, 1'b0);
    detSpeed <= 16'h64;
    ahb(1'b1, 32'h0, 32'h3);
    runCmd <= 1'b0;
    @(posedge clk);
    runCmd <= 1'b1;
    waitOut(1'b1, 4, 11);
    detSpeed <= 16'h5;
    repeat (15) @(posedge clk);
    chk("detected ignored", brake, 1'b1);
    refSpeed <= 16'h5;
    waitOut(1'b0, 0, 7);
    $display("test vector done");
    ahb(1'b1, 32'h18, 32'h0);
    runCmd <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      alarmTrip <= (k == 0);
      coastStop <= (k == 1);
      motorSelect <= (k == 2) ? 2'(1 + $urandom_range(2)) : 2'h0;
      // the output registered one edge after the force is seen at the next edge
      repeat (2) @(posedge clk);
      chk("forced on", brake, 1'b1);
      {alarmTrip, coastStop, motorSelect} <= '0;
      waitOut(1'b0, 0, 3);
    end
    $display("test forcing done");
    print_verdict();
  end
endmodule

/* hdl/hbss_pkg.sv */
// shared constants for the hoist brake signal sequencer
// assumes a 100 MHz clock and a 32-bit ahb-lite register port
package hbss_pkg;
  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIMER_RES_MS = 100;
  localparam int TICK_CYCLES = (TIMER_RES_MS * 1000000) / CLK_PERIOD_NS;
  localparam int TIMER_MAX_MS = 5000;
  localparam logic [5:0] TIMER_MAX_TICKS = 6'(TIMER_MAX_MS / TIMER_RES_MS);

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_REL_CUR = 8'h04;
  localparam logic [7:0] OFS_REL_FREQ = 8'h08;
  localparam logic [7:0] OFS_REL_TIMER = 8'h0c;
  localparam logic [7:0] OFS_ENG_FREQ = 8'h10;
  localparam logic [7:0] OFS_ENG_TIMER = 8'h14;
  localparam logic [7:0] OFS_REL_TORQ = 8'h18;
  localparam logic [7:0] OFS_STOP_FREQ = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_RATED_BASE = 8'h24;
  localparam logic [7:0] OFS_ASSIGN_BASE = 8'h30;

  // ------------------------------------------------------------------
  // control field positions and codes
  // ------------------------------------------------------------------
  localparam int CTRL_VECTOR_BIT = 0;
  localparam int CTRL_SPEEDSEL_BIT = 1;
  localparam int CTRL_DUTY_LSB = 2;
  localparam logic [1:0] DUTY_CONSTANT_TORQUE = 2'h0;
  localparam logic [1:0] DUTY_MEDIUM_TORQUE = 2'h1;
  localparam logic [1:0] DUTY_VARIABLE_TORQUE = 2'h2;
  localparam logic [7:0] BRAKE_ASSIGN_CODE = 8'h39;
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [8:0] PCT_MAX = 9'h12c;
  localparam logic [7:0] FREQ_MAX = 8'hfa;
  localparam logic [1:0] FIRST_MOTOR = 2'h0;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [3:0] RST_CTRL = 4'h0;
  localparam logic [8:0] RST_PCT = 9'h064;
  localparam logic [7:0] RST_FREQ = 8'h0a;
  localparam logic [5:0] RST_TIMER = 6'h01;
  localparam logic [15:0] RST_RATED = 16'h0064;
  localparam logic [7:0] RST_ASSIGN = 8'h00;

  // ------------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_ENGAGED = 3'b001,
    ST_RELEASED = 3'b010,
    ST_LOCKOUT = 3'b100
  } hbss_state_type;
endpackage

/* hdl/hbss_sequencer.sv */
// hoist brake signal sequencer: decides when the brake-release output is on
// assumes synchronous drive measurements and an ahb-lite master on one clock
// assumes the drive measurements arrive already scaled to the units of the settings
// Operation
// - release after level held for release dwell
// - current threshold 0..300 percent of rated
// - frequency threshold used only under v/f
// - torque threshold used only under vector
// - v/f engage: run off, freq low, dwell
// - vector engage: speed below stop level, dwell
// - speed select: 0 detected, 1 reference
// - motors two to four hold release on
// - alarm or coast stop forces output on
// - re-release needs run off then on
// - terminals with code 57 carry the signal
// - rated current follows chosen duty mode
`timescale 1ns/1ps
module hbss_sequencer #(
  parameter int TICK_CYCLES = hbss_pkg::TICK_CYCLES,
  parameter int NUM_TERMINALS = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [15:0] outCurrent,
  input wire logic [15:0] outFreq,
  input wire logic [15:0] torqueCmd,
  input wire logic [15:0] refSpeed,
  input wire logic [15:0] detSpeed,
  input wire logic runCmd,
  input wire logic alarmTrip,
  input wire logic coast_stop_cmd,
  input wire logic [1:0] motorSelect,
  output logic brake_release_out,
  output logic [NUM_TERMINALS-1:0] terminalOut
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  // every flip-flop of the block lives in this one record: dwell counters,
  // software settings, bus capture and outputs; keeping them together lets
  // a single process register the whole lot
  typedef struct packed {
    hbss_pkg::hbss_state_type state;
    logic [31:0] tickCnt;
    logic [5:0] relCnt;
    logic [5:0] engCnt;
    logic [3:0] ctrl;
    logic [8:0] release_current_level;
    logic [7:0] release_freq_level;
    logic [5:0] release_dwell_timer;
    logic [7:0] engage_freq_level;
    logic [5:0] engage_dwell_timer;
    logic [8:0] release_torque_level;
    logic [7:0] stop_freq_level;
    logic [2:0][15:0] rated;
    logic [NUM_TERMINALS-1:0][7:0] termCode;
    logic wrPend;
    logic rdPend;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic brakeOut;
    logic [NUM_TERMINALS-1:0] termOut;
  } hbss_regs_type;

  hbss_regs_type r_q;
  hbss_regs_type r_d;

  // decoded settings and comparison results, all settled within one cycle
  logic vectorMode;
  logic [1:0] dutyMode;
  logic [15:0] ratedCur;
  logic [15:0] cmpSpeed;
  logic [25:0] curScaled;
  logic [25:0] curLimit;
  logic relCond;
  logic engCond;
  logic tick;
  logic relDone;
  logic engDone;
  logic forceOn;
  logic otherMotor;
  logic [31:0] rv;

  // ------------------------------------------------------------------
  // fixed answers: zero wait states, always okay
  // ------------------------------------------------------------------
  // hsize is not decoded: every register is one aligned word, so a narrow
  // write still lands as the low bits of the whole word
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r_q.rdata;
  assign brake_release_out = r_q.brakeOut;
  assign terminalOut = r_q.termOut;

  // ------------------------------------------------------------------
  // comparisons and dwell qualification
  // ------------------------------------------------------------------
  always_comb begin
    vectorMode = r_q.ctrl[hbss_pkg::CTRL_VECTOR_BIT];
    dutyMode = r_q.ctrl[hbss_pkg::CTRL_DUTY_LSB +: 2];
    // rated current of the selected duty rating scales the percent level
    unique case (dutyMode)
      hbss_pkg::DUTY_MEDIUM_TORQUE: ratedCur = r_q.rated[1];
      hbss_pkg::DUTY_VARIABLE_TORQUE: ratedCur = r_q.rated[2];
      default: ratedCur = r_q.rated[0];
    endcase
    // avoids a divider: compare current*100 against level*rated
    curScaled = 26'(outCurrent) * 26'(hbss_pkg::PCT_FULL);
    curLimit = 26'(r_q.release_current_level) * 26'(ratedCur);
    cmpSpeed = r_q.ctrl[hbss_pkg::CTRL_SPEEDSEL_BIT] ? refSpeed : detSpeed;
    // release needs the run command in either control mode
    relCond = runCmd && (curScaled > curLimit);
    if (vectorMode) begin
      relCond = relCond || (runCmd && torqueCmd > 16'(r_q.release_torque_level));
      engCond = cmpSpeed < 16'(r_q.stop_freq_level);
    end else begin
      relCond = relCond || (runCmd && outFreq > 16'(r_q.release_freq_level));
      engCond = !runCmd && outFreq < 16'(r_q.engage_freq_level);
    end
    // free-running tick: a dwell may run up to one step short
    // one shared tick costs a single counter rather than one per timer
    tick = r_q.tickCnt == 32'(TICK_CYCLES - 1);
    relDone = relCond && r_q.relCnt >= r_q.release_dwell_timer;
    engDone = engCond && r_q.engCnt >= r_q.engage_dwell_timer;
    forceOn = alarmTrip || coast_stop_cmd;
    otherMotor = motorSelect != hbss_pkg::FIRST_MOTOR;
  end

  // ------------------------------------------------------------------
  // register readback from the post-write copy so a read right after a
  // write to the same word sees the new value
  // ------------------------------------------------------------------
  function automatic logic [31:0] readReg(input hbss_regs_type s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    unique case (a)
      hbss_pkg::OFS_CTRL: v = 32'(s.ctrl);
      hbss_pkg::OFS_REL_CUR: v = 32'(s.release_current_level);
      hbss_pkg::OFS_REL_FREQ: v = 32'(s.release_freq_level);
      hbss_pkg::OFS_REL_TIMER: v = 32'(s.release_dwell_timer);
      hbss_pkg::OFS_ENG_FREQ: v = 32'(s.engage_freq_level);
      hbss_pkg::OFS_ENG_TIMER: v = 32'(s.engage_dwell_timer);
      hbss_pkg::OFS_REL_TORQ: v = 32'(s.release_torque_level);
      hbss_pkg::OFS_STOP_FREQ: v = 32'(s.stop_freq_level);
      // status is read only: dwell count, one-hot state and the output bit
      hbss_pkg::OFS_STATUS: v = {19'h0, s.engCnt, s.state, s.brakeOut, 3'h0};
      default: begin
        for (int i = 0; i < 3; i++) begin
          if (a == 8'(hbss_pkg::OFS_RATED_BASE + 8'(4 * i))) begin
            v = 32'(s.rated[i]);
          end
        end
        for (int i = 0; i < NUM_TERMINALS; i++) begin
          if (a == 8'(hbss_pkg::OFS_ASSIGN_BASE + 8'(4 * i))) begin
            v = 32'(s.termCode[i]);
          end
        end
      end
    endcase
    return v;
  endfunction

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    rv = 32'h0;
    r_d.tickCnt = tick ? 32'h0 : r_q.tickCnt + 32'h1;

    // data phase of a write: levels and timers above range are clamped, except stop_freq_level, which keeps the low byte
    // clamping keeps a bad setting usable, and software reads back what took
    if (r_q.wrPend) begin
      unique case (r_q.addr)
        hbss_pkg::OFS_CTRL: r_d.ctrl = hwdata[3:0];
        hbss_pkg::OFS_REL_CUR: r_d.release_current_level =
          (hwdata > 32'(hbss_pkg::PCT_MAX)) ? hbss_pkg::PCT_MAX : hwdata[8:0];
        hbss_pkg::OFS_REL_FREQ: r_d.release_freq_level =
          (hwdata > 32'(hbss_pkg::FREQ_MAX)) ? hbss_pkg::FREQ_MAX : hwdata[7:0];
        hbss_pkg::OFS_REL_TIMER: r_d.release_dwell_timer =
          (hwdata > 32'(hbss_pkg::TIMER_MAX_TICKS)) ? hbss_pkg::TIMER_MAX_TICKS : hwdata[5:0];
        hbss_pkg::OFS_ENG_FREQ: r_d.engage_freq_level =
          (hwdata > 32'(hbss_pkg::FREQ_MAX)) ? hbss_pkg::FREQ_MAX : hwdata[7:0];
        hbss_pkg::OFS_ENG_TIMER: r_d.engage_dwell_timer =
          (hwdata > 32'(hbss_pkg::TIMER_MAX_TICKS)) ? hbss_pkg::TIMER_MAX_TICKS : hwdata[5:0];
        hbss_pkg::OFS_REL_TORQ: r_d.release_torque_level =
          (hwdata > 32'(hbss_pkg::PCT_MAX)) ? hbss_pkg::PCT_MAX : hwdata[8:0];
        hbss_pkg::OFS_STOP_FREQ: r_d.stop_freq_level = hwdata[7:0];
        default: begin
          for (int i = 0; i < 3; i++) begin
            if (r_q.addr == 8'(hbss_pkg::OFS_RATED_BASE + 8'(4 * i))) begin
              r_d.rated[i] = hwdata[15:0];
            end
          end
          for (int i = 0; i < NUM_TERMINALS; i++) begin
            if (r_q.addr == 8'(hbss_pkg::OFS_ASSIGN_BASE + 8'(4 * i))) begin
              r_d.termCode[i] = hwdata[7:0];
            end
          end
        end
      endcase
    end

    // address phase capture
    // only the low byte of the address selects a register
    r_d.wrPend = 1'b0;
    r_d.rdPend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      r_d.addr = haddr[7:0];
      r_d.wrPend = hwrite;
      r_d.rdPend = !hwrite;
      // unmapped high addresses read as zero
      if (!hwrite) begin
        rv = (haddr[31:8] == 24'h0) ? readReg(r_d, haddr[7:0]) : 32'h0;
        r_d.rdata = rv;
      end
      if (haddr[31:8] != 24'h0) begin
        r_d.wrPend = 1'b0;
      end
    end

    // dwell counters restart as soon as the condition drops
    // and stop once done, so a long hold cannot wrap them
    if (!relCond) begin
      r_d.relCnt = 6'h0;
    end else if (tick && !relDone) begin
      r_d.relCnt = r_q.relCnt + 6'h1;
    end
    if (!engCond) begin
      r_d.engCnt = 6'h0;
    end else if (tick && !engDone) begin
      r_d.engCnt = r_q.engCnt + 6'h1;
    end

    // sequencer
    // lockout remembers that this run already had its release, so a brake
    // dropped mid-run is not lifted again by the same run command
    unique case (r_q.state)
      hbss_pkg::ST_ENGAGED: begin
        if (relDone) begin
          r_d.state = hbss_pkg::ST_RELEASED;
          r_d.engCnt = 6'h0;
        end
      end
      hbss_pkg::ST_RELEASED: begin
        if (engDone) begin
          r_d.state = hbss_pkg::ST_LOCKOUT;
        end
      end
      hbss_pkg::ST_LOCKOUT: begin
        // run must be seen off before a new release can start
        if (!runCmd) begin
          r_d.state = hbss_pkg::ST_ENGAGED;
          r_d.relCnt = 6'h0;
        end
      end
      default: r_d.state = hbss_pkg::ST_ENGAGED;
    endcase

    // output: force and other motors override the sequencer
    // forcing leaves the state alone, so the sequence resumes where it was
    r_d.brakeOut = forceOn || otherMotor || (r_d.state == hbss_pkg::ST_RELEASED);
    for (int i = 0; i < NUM_TERMINALS; i++) begin
      r_d.termOut[i] = r_d.brakeOut && (r_d.termCode[i] == hbss_pkg::BRAKE_ASSIGN_CODE);
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  // synchronous reset: settings return to their defaults and the brake
  // output starts engaged until the first sequenced or forced release
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_q <= '0;
      r_q.state <= hbss_pkg::ST_ENGAGED;
      r_q.ctrl <= hbss_pkg::RST_CTRL;
      r_q.release_current_level <= hbss_pkg::RST_PCT;
      r_q.release_freq_level <= hbss_pkg::RST_FREQ;
      r_q.release_dwell_timer <= hbss_pkg::RST_TIMER;
      r_q.engage_freq_level <= hbss_pkg::RST_FREQ;
      r_q.engage_dwell_timer <= hbss_pkg::RST_TIMER;
      r_q.release_torque_level <= hbss_pkg::RST_PCT;
      r_q.stop_freq_level <= hbss_pkg::RST_FREQ;
      r_q.rated <= {3{hbss_pkg::RST_RATED}};
      r_q.termCode <= {NUM_TERMINALS{hbss_pkg::RST_ASSIGN}};
    end else begin
      r_q <= r_d;
    end
  end
endmodule
